// ### rtl/srpm_cfg.svh
`ifndef SRPM_CFG_SVH
`define SRPM_CFG_SVH

// Address byte: fixed upper nibble, strap bits below, direction last
`define SRPM_ADDR_FIXED   4'h9

// Index values of the data registers
`define SRPM_IDX_TEMP     8'h00
`define SRPM_IDX_CFG      8'h01
`define SRPM_IDX_LOW      8'h02
`define SRPM_IDX_HIGH     8'h03
`define SRPM_IDX_NV_CFG   8'h11
`define SRPM_IDX_NV_LOW   8'h12
`define SRPM_IDX_NV_HIGH  8'h13
// Additional command: copy stored registers into active ones
`define SRPM_CMD_COPY     8'ha8

// Reset values
`define SRPM_PTR_RST      8'h00
`define SRPM_TEMP_RST     16'h0000
`define SRPM_NV_CFG_RST   16'h0000
`define SRPM_NV_LOW_RST   16'h4b00
`define SRPM_NV_HIGH_RST  16'h5000

// Shutdown bit inside the configuration word
`define SRPM_SD_BIT       8

// Controller register offsets
`define SRPM_R_CMD        3'h0
`define SRPM_R_INDEX      3'h1
`define SRPM_R_WDATA      3'h2
`define SRPM_R_RDATA      3'h3
`define SRPM_R_STATUS     3'h4
`define SRPM_R_STRAP      3'h5

// Command word fields
`define SRPM_CMD_RD_BIT   0
`define SRPM_CMD_CNT_LSB  1
`define SRPM_CMD_COPY_BIT 3

// Link timing
`define SRPM_CLK_NS       4
`define SRPM_HALF_NS      1250
`define SRPM_QTR_CYC      ((`SRPM_HALF_NS / 2) / `SRPM_CLK_NS)

`endif

// ### rtl/srpm_pkg.sv
package srpm_pkg;

  typedef enum logic [2:0] {
    SRPM_S_IDLE  = 3'b000,
    SRPM_S_ADDR  = 3'b001,
    SRPM_S_WRITE = 3'b010,
    SRPM_S_ACK   = 3'b011,
    SRPM_S_READ  = 3'b100,
    SRPM_S_MACK  = 3'b101,
    SRPM_S_RNEXT = 3'b110
  } srpm_dev_st_t;

  typedef enum logic [1:0] {
    SRPM_C_IDLE  = 2'b00,
    SRPM_C_START = 2'b01,
    SRPM_C_BITS  = 2'b10,
    SRPM_C_STOP  = 2'b11
  } srpm_ctl_st_t;

endpackage

// ### rtl/srpm_link_if.sv
`timescale 1ns/1ps
interface srpm_link_if;
  logic ctl_scl_out;
  logic ctl_scl_oe_n;
  logic ctl_sda_out;
  logic ctl_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups
  assign scl = ~(~ctl_scl_oe_n & ~ctl_scl_out);
  assign sda = ~((~ctl_sda_oe_n & ~ctl_sda_out) | (~dev_sda_oe_n & ~dev_sda_out));

  modport ctl (output ctl_scl_out, output ctl_scl_oe_n, output ctl_sda_out, output ctl_sda_oe_n,
               input scl, input sda);
  modport dev (output dev_sda_out, output dev_sda_oe_n, input scl, input sda);
endinterface

// ### rtl/srpm_sensor_end.sv
`timescale 1ns/1ps
`include "srpm_cfg.svh"

// Summary of operation
// - Index byte selects one of seven registers
// - Index persists across reads until rewritten
// - First write byte is the index or the copy command
// - Controller resends index on every write except copy, which sends the command byte
// - Controller keeps three upper index bits zero
// - Nonzero upper bits may decode as command
// - Unknown index: keep index, answer negative
// - Address byte with write, acknowledge, index
// - Index is zero after reset
// - Reset loads active copies from stored
// - Sensing uses active copies only
// - Active and stored copies written independently
// - Controller issues copy only when the command copy bit is set
// - Upper-byte-only configuration access accepted
// - Shutdown start still measures once
// - Controller selects register before write data; reads use the held index
// - Read address acknowledged, upper byte first
// - Measurement writes dropped, bytes negatively acknowledged
module srpm_sensor_end
  import srpm_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic        ce_in,
  srpm_link_if.dev         link,
  input  wire logic [2:0]  strap_pins_in,
  input  wire logic [15:0] measure_in,
  input  wire logic        measure_valid_in,
  output logic             measure_req_out,
  output logic [15:0]      active_configuration_out,
  output logic [15:0]      active_low_limit_out,
  output logic [15:0]      active_high_limit_out
);

  logic [2:0]   scl_q;
  logic [2:0]   sda_q;
  logic [2:0]   strap_m;
  logic [2:0]   strap_s;
  srpm_dev_st_t st;
  logic [3:0]   cnt;
  logic [7:0]   sh;
  logic [1:0]   byte_n;
  logic         rd_mode;
  logic         ack_pend;
  logic         idx_ok;
  logic         lo_next;
  logic [7:0]   tx;
  logic         sda_oe_n;
  logic [7:0]   register_index;
  logic         load_pend;
  logic [15:0]  measured_temperature;
  logic [15:0]  active_configuration;
  logic [15:0]  active_low_limit;
  logic [15:0]  active_high_limit;
  logic [15:0]  stored_configuration;
  logic [15:0]  stored_low_limit;
  logic [15:0]  stored_high_limit;
  logic [15:0]  sel_word;
  logic [7:0]   byte_in;
  logic [7:0]   next_byte;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;
  logic         byte_done;
  logic         idx_take;
  logic         cmd_copy;
  logic         data_wr;
  logic         ack_d;
  logic         rd_busy;

  function automatic logic idx_valid(input logic [7:0] b);
    case (b)
      `SRPM_IDX_TEMP, `SRPM_IDX_CFG, `SRPM_IDX_LOW, `SRPM_IDX_HIGH,
      `SRPM_IDX_NV_CFG, `SRPM_IDX_NV_LOW, `SRPM_IDX_NV_HIGH: idx_valid = 1'b1;
      default: idx_valid = 1'b0;
    endcase
  endfunction

  assign link.dev_sda_out       = 1'b0;
  assign link.dev_sda_oe_n      = sda_oe_n;
  assign active_configuration_out = active_configuration;
  assign active_low_limit_out   = active_low_limit;
  assign active_high_limit_out  = active_high_limit;

  // Pin synchronisers
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_q   <= 3'h7;
      sda_q   <= 3'h7;
      strap_m <= 3'h0;
      strap_s <= 3'h0;
    end else if (ce_in) begin
      scl_q   <= {scl_q[1:0], link.scl};
      sda_q   <= {sda_q[1:0], link.sda};
      strap_m <= strap_pins_in;
      strap_s <= strap_m;
    end
  end

  assign scl_rise  = scl_q[1] & ~scl_q[2];
  assign scl_fall  = ~scl_q[1] & scl_q[2];
  assign start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop_det  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  assign byte_in   = {sh[6:0], sda_q[1]};
  assign byte_done = ce_in & scl_rise & ~start_det & ~stop_det & (cnt == 4'h7);
  assign idx_take  = byte_done & (st == SRPM_S_WRITE) & (byte_n == 2'h0);
  assign cmd_copy  = idx_take & (byte_in == `SRPM_CMD_COPY);
  assign data_wr   = byte_done & (st == SRPM_S_WRITE) & (byte_n != 2'h0) & (byte_n != 2'h3) & idx_ok
                     & (register_index != `SRPM_IDX_TEMP);
  assign rd_busy   = rd_mode & (st != SRPM_S_IDLE) & (st != SRPM_S_ADDR);

  always_comb begin
    if (st == SRPM_S_ADDR) begin
      ack_d = (byte_in[7:1] == {`SRPM_ADDR_FIXED, strap_s});
    end else if (byte_n == 2'h0) begin
      ack_d = idx_valid(byte_in) | (byte_in == `SRPM_CMD_COPY);
    end else begin
      ack_d = (byte_n != 2'h3) & idx_ok & (register_index != `SRPM_IDX_TEMP);
    end
  end

  always_comb begin
    case (register_index)
      `SRPM_IDX_CFG:     sel_word = active_configuration;
      `SRPM_IDX_LOW:     sel_word = active_low_limit;
      `SRPM_IDX_HIGH:    sel_word = active_high_limit;
      `SRPM_IDX_NV_CFG:  sel_word = stored_configuration;
      `SRPM_IDX_NV_LOW:  sel_word = stored_low_limit;
      `SRPM_IDX_NV_HIGH: sel_word = stored_high_limit;
      default:           sel_word = measured_temperature;
    endcase
  end

  assign next_byte = (st == SRPM_S_ACK || !lo_next) ? sel_word[15:8] : sel_word[7:0];

  // Index register
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      register_index <= `SRPM_PTR_RST;
    end else if (ce_in) begin
      if (idx_take && idx_valid(byte_in)) begin
        register_index <= byte_in;
      end
    end
  end

  // Data registers
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      load_pend            <= 1'b1;
      measured_temperature <= `SRPM_TEMP_RST;
      active_configuration <= `SRPM_NV_CFG_RST;
      active_low_limit     <= `SRPM_NV_LOW_RST;
      active_high_limit    <= `SRPM_NV_HIGH_RST;
      stored_configuration <= `SRPM_NV_CFG_RST;
      stored_low_limit     <= `SRPM_NV_LOW_RST;
      stored_high_limit    <= `SRPM_NV_HIGH_RST;
    end else if (ce_in) begin
      load_pend <= 1'b0;
      if (measure_valid_in && !rd_busy) begin
        measured_temperature <= measure_in;
      end
      if (load_pend || cmd_copy) begin
        active_configuration <= stored_configuration;
        active_low_limit     <= stored_low_limit;
        active_high_limit    <= stored_high_limit;
      end else if (data_wr) begin
        case (register_index)
          `SRPM_IDX_CFG:     active_configuration <= put_byte(active_configuration, byte_n, byte_in);
          `SRPM_IDX_LOW:     active_low_limit     <= put_byte(active_low_limit, byte_n, byte_in);
          `SRPM_IDX_HIGH:    active_high_limit    <= put_byte(active_high_limit, byte_n, byte_in);
          `SRPM_IDX_NV_CFG:  stored_configuration <= put_byte(stored_configuration, byte_n, byte_in);
          `SRPM_IDX_NV_LOW:  stored_low_limit     <= put_byte(stored_low_limit, byte_n, byte_in);
          `SRPM_IDX_NV_HIGH: stored_high_limit    <= put_byte(stored_high_limit, byte_n, byte_in);
          default: ;
        endcase
      end
    end
  end

  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic [1:0] n, input logic [7:0] b);
    put_byte = (n == 2'h1) ? {b, w[7:0]} : {w[15:8], b};
  endfunction

  // Measurement request from active configuration
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      measure_req_out <= 1'b1;
    end else if (ce_in) begin
      if (measure_valid_in) begin
        measure_req_out <= ~active_configuration[`SRPM_SD_BIT];
      end else if (!active_configuration[`SRPM_SD_BIT]) begin
        measure_req_out <= 1'b1;
      end
    end
  end

  // Byte-level link sequencer
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st       <= SRPM_S_IDLE;
      cnt      <= 4'h0;
      sh       <= 8'h00;
      byte_n   <= 2'h0;
      rd_mode  <= 1'b0;
      ack_pend <= 1'b0;
      idx_ok   <= 1'b0;
      lo_next  <= 1'b0;
      tx       <= 8'h00;
      sda_oe_n <= 1'b1;
    end else if (ce_in) begin
      if (stop_det) begin
        st       <= SRPM_S_IDLE;
        sda_oe_n <= 1'b1;
      end else if (start_det) begin
        st       <= SRPM_S_ADDR;
        cnt      <= 4'h0;
        byte_n   <= 2'h0;
        idx_ok   <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (scl_rise) begin
        case (st)
          SRPM_S_ADDR, SRPM_S_WRITE: begin
            sh  <= byte_in;
            cnt <= cnt + 4'h1;
            if (cnt == 4'h7) begin
              ack_pend <= ack_d;
              if (st == SRPM_S_ADDR) begin
                rd_mode <= byte_in[0];
              end else if (byte_n != 2'h3) begin
                byte_n <= byte_n + 2'h1;
              end
              if (idx_take) begin
                idx_ok <= idx_valid(byte_in);
              end
            end
          end
          SRPM_S_MACK: st <= sda_q[1] ? SRPM_S_IDLE : SRPM_S_RNEXT;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (st)
          SRPM_S_ADDR, SRPM_S_WRITE: begin
            if (cnt == 4'h8) begin
              sda_oe_n <= ~ack_pend;
              st       <= SRPM_S_ACK;
            end
          end
          SRPM_S_ACK: begin
            cnt <= 4'h1;
            if (!ack_pend && byte_n == 2'h0) begin
              st       <= SRPM_S_IDLE;
              sda_oe_n <= 1'b1;
            end else if (rd_mode) begin
              sda_oe_n <= next_byte[7];
              tx       <= {next_byte[6:0], 1'b0};
              lo_next  <= 1'b1;
              st       <= SRPM_S_READ;
            end else begin
              sda_oe_n <= 1'b1;
              cnt      <= 4'h0;
              st       <= SRPM_S_WRITE;
            end
          end
          SRPM_S_READ: begin
            if (cnt == 4'h8) begin
              sda_oe_n <= 1'b1;
              st       <= SRPM_S_MACK;
            end else begin
              sda_oe_n <= tx[7];
              tx       <= {tx[6:0], 1'b0};
              cnt      <= cnt + 4'h1;
            end
          end
          SRPM_S_RNEXT: begin
            sda_oe_n <= next_byte[7];
            tx       <= {next_byte[6:0], 1'b0};
            lo_next  <= ~lo_next;
            cnt      <= 4'h1;
            st       <= SRPM_S_READ;
          end
          default: ;
        endcase
      end
    end
  end

endmodule // srpm_sensor_end

// ### rtl/srpm_bus_ctrl.sv
`timescale 1ns/1ps
`include "srpm_cfg.svh"

module srpm_bus_ctrl
  import srpm_pkg::*;
#(
  parameter int unsigned QTR_CYC = `SRPM_QTR_CYC
)(
  input  wire logic        mclk_in,
  input  wire logic        nrst_in,
  input  wire logic        ce_in,
  srpm_link_if.ctl         link,
  input  wire logic [2:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [15:0]      rdata_out
);

  logic [1:0]   sda_q;
  srpm_ctl_st_t st;
  logic [15:0]  qcnt;
  logic [1:0]   q;
  logic [1:0]   byte_i;
  logic [1:0]   n_last;
  logic [3:0]   bit_i;
  logic         rd_kind;
  logic         copy_sel;
  logic         busy;
  logic         nack;
  logic         scl_oe_n;
  logic         sda_oe_n;
  logic [4:0]   index_sel;
  logic [15:0]  wdata;
  logic [15:0]  rx_data;
  logic [2:0]   strap_sel;
  logic [15:0]  reg_mux;
  logic         qtick;
  logic         is_tx;
  logic         launch;
  logic [7:0]   cur_byte;

  function automatic logic [7:0] tx_byte(input logic [1:0] i);
    case (i)
      2'h0:    tx_byte = {`SRPM_ADDR_FIXED, strap_sel, rd_kind};
      2'h1:    tx_byte = copy_sel ? `SRPM_CMD_COPY : {3'h0, index_sel};
      2'h2:    tx_byte = wdata[15:8];
      default: tx_byte = wdata[7:0];
    endcase
  endfunction

  assign link.ctl_scl_out  = 1'b0;
  assign link.ctl_sda_out  = 1'b0;
  assign link.ctl_scl_oe_n = scl_oe_n;
  assign link.ctl_sda_oe_n = sda_oe_n;
  assign qtick    = ce_in && (st != SRPM_C_IDLE) && (qcnt == 16'(QTR_CYC - 1));
  assign is_tx    = !rd_kind || (byte_i == 2'h0);
  assign launch   = wr_in && (addr_in == `SRPM_R_CMD) && !busy;
  always_comb begin
    cur_byte = tx_byte(byte_i);
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sda_q <= 2'h3;
    end else if (ce_in) begin
      sda_q <= {sda_q[0], link.sda};
    end
  end

  // Software registers
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      index_sel <= 5'h00;
      wdata     <= 16'h0000;
      strap_sel <= 3'h0;
    end else if (ce_in && wr_in && !busy) begin
      case (addr_in)
        `SRPM_R_INDEX: index_sel <= wdata_in[4:0];
        `SRPM_R_WDATA: wdata     <= wdata_in;
        `SRPM_R_STRAP: strap_sel <= wdata_in[2:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    case (addr_in)
      `SRPM_R_INDEX:  reg_mux = {11'h000, index_sel};
      `SRPM_R_WDATA:  reg_mux = wdata;
      `SRPM_R_RDATA:  reg_mux = rx_data;
      `SRPM_R_STATUS: reg_mux = {14'h0000, nack, busy};
      `SRPM_R_STRAP:  reg_mux = {13'h0000, strap_sel};
      default:        reg_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= 16'h0000;
    end else if (ce_in) begin
      rdata_out <= rd_in ? reg_mux : 16'h0000;
    end
  end

  // Quarter-bit timer
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      qcnt <= 16'h0000;
    end else if (ce_in) begin
      qcnt <= (qtick || st == SRPM_C_IDLE) ? 16'h0000 : qcnt + 16'h0001;
    end
  end

  // Link sequencer
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st       <= SRPM_C_IDLE;
      q        <= 2'h0;
      byte_i   <= 2'h0;
      n_last   <= 2'h0;
      bit_i    <= 4'h0;
      rd_kind  <= 1'b0;
      copy_sel <= 1'b0;
      busy     <= 1'b0;
      nack     <= 1'b0;
      rx_data  <= 16'h0000;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (ce_in) begin
      if (launch) begin
        rd_kind  <= wdata_in[`SRPM_CMD_RD_BIT];
        copy_sel <= wdata_in[`SRPM_CMD_COPY_BIT];
        n_last   <= wdata_in[`SRPM_CMD_RD_BIT] ? ((wdata_in[2:1] == 2'h2) ? 2'h2 : 2'h1)
                                               : ((wdata_in[2:1] == 2'h3) ? 2'h3 : 2'h1 + wdata_in[2:1]);
        st       <= SRPM_C_START;
        q        <= 2'h0;
        byte_i   <= 2'h0;
        bit_i    <= 4'h0;
        busy     <= 1'b1;
        nack     <= 1'b0;
        rx_data  <= 16'h0000;
      end else if (qtick) begin
        q <= q + 2'h1;
        case (st)
          SRPM_C_START: begin
            if (q == 2'h1) begin
              sda_oe_n <= 1'b0;
            end else if (q == 2'h3) begin
              scl_oe_n <= 1'b0;
              st       <= SRPM_C_BITS;
            end
          end
          SRPM_C_BITS: begin
            case (q)
              2'h0: begin
                if (bit_i != 4'h8) begin
                  sda_oe_n <= is_tx ? cur_byte[3'(4'h7 - bit_i)] : 1'b1;
                end else begin
                  sda_oe_n <= is_tx || (byte_i == n_last);
                end
              end
              2'h1: scl_oe_n <= 1'b1;
              2'h2: begin
                if (bit_i != 4'h8 && !is_tx) begin
                  rx_data <= {rx_data[14:0], sda_q[1]};
                end else if (bit_i == 4'h8 && is_tx && sda_q[1]) begin
                  nack <= 1'b1;
                end
              end
              default: begin
                scl_oe_n <= 1'b0;
                if (bit_i == 4'h8) begin
                  bit_i <= 4'h0;
                  if (nack || byte_i == n_last) begin
                    st <= SRPM_C_STOP;
                  end else begin
                    byte_i <= byte_i + 2'h1;
                  end
                end else begin
                  bit_i <= bit_i + 4'h1;
                end
              end
            endcase
          end
          SRPM_C_STOP: begin
            case (q)
              2'h0: sda_oe_n <= 1'b0;
              2'h1: scl_oe_n <= 1'b1;
              2'h2: sda_oe_n <= 1'b1;
              default: begin
                st   <= SRPM_C_IDLE;
                busy <= 1'b0;
              end
            endcase
          end
          default: ;
        endcase
      end
    end
  end

endmodule // srpm_bus_ctrl

// ### dv/srpm_link_assertions.sv
`timescale 1ns/1ps
module srpm_link_assertions (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic ctl_scl_out,
  input wire logic ctl_scl_oe_n,
  input wire logic ctl_sda_out,
  input wire logic ctl_sda_oe_n,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  a_drain_levels_low: assert property (!ctl_scl_out && !ctl_sda_out && !dev_sda_out)
    else $error("open drain level not low");
  a_reset_bus_quiet: assert property ($rose(nrst_in) |-> ctl_scl_oe_n && ctl_sda_oe_n && dev_sda_oe_n)
    else $error("bus driven right after reset");
  a_dev_moves_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device data moved while clock high");
  a_dev_holds_high: assert property (!dev_sda_oe_n && $rose(scl) |-> !dev_sda_oe_n [*4])
    else $error("device data released in clock high");
  a_dev_waits_fall: assert property ($fell(dev_sda_oe_n) |-> !scl && !$past(scl))
    else $error("device drove before clock fall");
  a_clock_high_len: assert property ($rose(ctl_scl_oe_n) |-> ctl_scl_oe_n [*7])
    else $error("clock high phase too short");
  a_clock_low_len: assert property ($fell(ctl_scl_oe_n) |-> !ctl_scl_oe_n [*7])
    else $error("clock low phase too short");
  a_stop_then_idle: assert property (scl && $rose(sda) |-> ctl_scl_oe_n [*4])
    else $error("clock pulled after stop");

  c_start_seen: cover property (scl && $fell(sda));
  c_dev_drives: cover property ($fell(dev_sda_oe_n));
  c_stop_seen: cover property (scl && $rose(sda));
endmodule // srpm_link_assertions

// ### dv/sensor_register_pointer_map_tb.sv
`timescale 1ns/1ps
module sensor_register_pointer_map_tb;
  logic        mclk_in;
  logic        nrst_in;
  logic [2:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [15:0] meas;
  logic        meas_vld;
  logic        meas_req;
  logic [15:0] act_cfg;
  logic [15:0] act_low;
  logic [15:0] act_high;
  logic [15:0] st;
  logic [15:0] wd;
  logic        nk;
  int          err_total;
  int          tests_run;

  srpm_link_if srpm_link_if_inst ();
  srpm_sensor_end srpm_sensor_end_inst (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .link(srpm_link_if_inst), .strap_pins_in(3'h5), .measure_in(meas), .measure_valid_in(meas_vld),
    .measure_req_out(meas_req), .active_configuration_out(act_cfg), .active_low_limit_out(act_low),
    .active_high_limit_out(act_high));
  srpm_bus_ctrl #(.QTR_CYC(4)) srpm_bus_ctrl_inst (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(1'b1),
    .link(srpm_link_if_inst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
  srpm_link_assertions srpm_link_assertions_inst (.mclk_in(mclk_in), .nrst_in(nrst_in),
    .ctl_scl_out(srpm_link_if_inst.ctl_scl_out), .ctl_scl_oe_n(srpm_link_if_inst.ctl_scl_oe_n),
    .ctl_sda_out(srpm_link_if_inst.ctl_sda_out), .ctl_sda_oe_n(srpm_link_if_inst.ctl_sda_oe_n),
    .dev_sda_out(srpm_link_if_inst.dev_sda_out), .dev_sda_oe_n(srpm_link_if_inst.dev_sda_oe_n),
    .scl(srpm_link_if_inst.scl), .sda(srpm_link_if_inst.sda));

  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task reg_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask

  task reg_rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // One link transfer: index, data word, command, then wait and collect status and word
  task xfer(input logic [4:0] idx, input logic [15:0] d, input logic [15:0] cmd);
    int i;
    reg_wr(3'h1, {11'h0, idx});
    reg_wr(3'h2, d);
    reg_wr(3'h0, cmd);
    for (i = 0; i < 2000; i++) begin
      reg_rd(3'h4, st);
      if (st[0] === 1'b0) break;
    end
    if (i == 2000) begin
      err_total++;
      test_done();
    end
    nk = st[1];
    reg_rd(3'h3, wd);
  endtask

  task s_reset;
    #1;
    chk(act_cfg, 16'h0000);
    chk(act_low, 16'h4b00);
    chk(act_high, 16'h5000);
    chk({15'h0, meas_req}, 16'h0001);
    xfer(5'h03, 16'h0000, 16'h0005);
    chk(wd, 16'h0000);
    chk({15'h0, nk}, 16'h0000);
  endtask

  task s_regs;
    logic [4:0]  idx [6];
    logic [15:0] val [6];
    idx = '{5'h01, 5'h02, 5'h03, 5'h11, 5'h12, 5'h13};
    val = '{16'h1234, 16'h0a20, 16'h7d00, 16'h0010, 16'hc900, 16'h3280};
    foreach (idx[k]) begin
      xfer(idx[k], val[k], 16'h0004);
      chk({15'h0, nk}, 16'h0000);
      xfer(5'h00, 16'h0000, 16'h0005);
      chk(wd, val[k]);
      xfer(5'h00, 16'h0000, 16'h0005);
      chk(wd, val[k]);
    end
    chk(act_cfg, 16'h1234);
    chk(act_low, 16'h0a20);
    chk(act_high, 16'h7d00);
  endtask

  task s_copy;
    xfer(5'h00, 16'h0000, 16'h0008);
    chk({15'h0, nk}, 16'h0000);
    chk(act_cfg, 16'h0010);
    chk(act_low, 16'hc900);
    chk(act_high, 16'h3280);
  endtask

  task s_bad_index;
    xfer(5'h01, 16'hffff, 16'h0000);
    chk(act_cfg, 16'h0010);
    xfer(5'h05, 16'h0000, 16'h0000);
    chk({15'h0, nk}, 16'h0001);
    xfer(5'h10, 16'h0000, 16'h0000);
    chk({15'h0, nk}, 16'h0001);
    xfer(5'h00, 16'h0000, 16'h0005);
    chk(wd, 16'h0010);
  endtask

  task s_measure;
    @(posedge mclk_in);
    meas <= 16'h1940;
    meas_vld <= 1'b1;
    @(posedge mclk_in);
    meas_vld <= 1'b0;
    xfer(5'h00, 16'hffff, 16'h0002);
    chk({15'h0, nk}, 16'h0001);
    xfer(5'h00, 16'h0000, 16'h0005);
    chk(wd, 16'h1940);
    chk({15'h0, meas_req}, 16'h0001);
  endtask

  task s_upper_only;
    xfer(5'h01, 16'hab00, 16'h0002);
    chk({15'h0, nk}, 16'h0000);
    chk(act_cfg, 16'hab10);
    xfer(5'h01, 16'hcd00, 16'h0002);
    chk({15'h0, nk}, 16'h0000);
    chk(act_cfg, 16'hcd10);
    xfer(5'h00, 16'h0000, 16'h0003);
    chk({8'h0, wd[7:0]}, 16'h00cd);
    // Shutdown set: next measurement ends sensing
    @(posedge mclk_in);
    meas_vld <= 1'b1;
    @(posedge mclk_in);
    meas_vld <= 1'b0;
    #1;
    chk({15'h0, meas_req}, 16'h0000);
  endtask

  task s_strap;
    reg_wr(3'h5, 16'h0002);
    xfer(5'h00, 16'h0000, 16'h0005);
    chk({15'h0, nk}, 16'h0001);
    reg_wr(3'h5, 16'h0005);
    reg_wr(3'h1, 16'h00f3);
    reg_rd(3'h1, wd);
    chk(wd, 16'h0013);
  endtask

  initial begin
    nrst_in = 1'b0;
    addr = 3'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    meas = 16'h0000;
    meas_vld = 1'b0;
    err_total = 0;
    tests_run = 0;
    repeat (5) @(posedge mclk_in);
    nrst_in <= 1'b1;
    reg_wr(3'h5, 16'h0005);
    s_reset();
    s_regs();
    s_copy();
    s_bad_index();
    s_measure();
    s_upper_only();
    s_strap();
    test_done();
  end
endmodule // sensor_register_pointer_map_tb
